// *** src/temperature_sample_fifo.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "sample_fifo_defines.svh"
module temperature_sample_fifo #(
  parameter int DEPTH_LOG2 = 5
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire sample_fifo_pkg::reg_req_t req,
  output logic [7:0] rdata,
  input wire logic sample_valid,
  input wire logic [15:0] sample_word,
  input wire logic almost_full_en,
  input wire logic [1:0] pin0_function_select,
  output logic general_pin_0,
  output logic almost_full
);
  localparam int DEPTH = 1 << DEPTH_LOG2;

  // no reset on storage: a slot means nothing until it is pushed
  logic [15:0] mem [DEPTH];

  // write side
  logic [4:0] write_index_r, write_index_nxt;

  // read side and the byte phase of the data port
  logic [4:0] read_index_r, read_index_nxt;
  logic low_byte_r, low_byte_nxt;

  // occupancy and loss bookkeeping
  logic [4:0] lost_word_count_r, lost_word_count_nxt;
  logic [5:0] count_r, count_nxt;

  // almost-full flag and the condition seen last cycle
  logic flag_r, flag_nxt;
  logic cond_r, cond_nxt;
  logic cond_now;
  logic [5:0] thresh;

  // settings held from the two configuration registers
  sample_fifo_pkg::fifo_cfg_t cfg_r, cfg_nxt;

  // read data staging
  logic [7:0] rdata_nxt;

  // decoded strobes and buffer events
  logic data_rd, status_rd;
  logic rd_index_wr, watermark_wr, behaviour_wr;
  logic full, empty, pop, push, store, flush;
  logic grow, shrink;

  assign status_rd = req.rd && (req.addr == `ADDR_STATUS);
  assign data_rd = req.rd && (req.addr == `ADDR_DATA_PORT);
  assign rd_index_wr = req.wr && (req.addr == `ADDR_READ_INDEX);
  assign watermark_wr = req.wr && (req.addr == `ADDR_WATERMARK);
  assign behaviour_wr = req.wr && (req.addr == `ADDR_BEHAVIOUR);

  assign full = (count_r == `DEPTH_WORDS);
  assign empty = (count_r == 6'h00);
  // a word leaves only once its lower byte has gone out
  assign pop = data_rd && low_byte_r && !empty;
  assign push = sample_valid;
  assign store = push && (!full || cfg_r.overwrite);
  assign flush = behaviour_wr && req.wdata[`BIT_FLUSH];
  assign grow = store && !full && !pop;
  assign shrink = pop && !store;
  assign thresh = `DEPTH_WORDS - {1'b0, cfg_r.watermark};

  always_comb
  begin
    write_index_nxt = write_index_r;
    if (store)
      write_index_nxt = write_index_r + 5'h01;
    if (flush)
      write_index_nxt = 5'h00;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      write_index_r <= 5'h00;
    end
    else
    begin
      write_index_r <= write_index_nxt;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (store)
      mem[write_index_r] <= sample_word;
  end

  always_comb
  begin
    read_index_nxt = read_index_r;
    low_byte_nxt = low_byte_r;
    if (data_rd && !empty)
      low_byte_nxt = !low_byte_r;
    if (rd_index_wr)
    begin
      read_index_nxt = req.wdata[4:0];
      low_byte_nxt = 1'b0;
    end
    // a rollover push steps past the word it destroyed
    if (pop)
      read_index_nxt = read_index_r + 5'h01;
    else if (store && full)
      read_index_nxt = read_index_r + 5'h01;
    if (flush)
    begin
      read_index_nxt = 5'h00;
      low_byte_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      read_index_r <= 5'h00;
      low_byte_r <= 1'b0;
    end
    else
    begin
      read_index_r <= read_index_nxt;
      low_byte_r <= low_byte_nxt;
    end
  end

  always_comb
  begin
    lost_word_count_nxt = lost_word_count_r;
    if (pop)
      lost_word_count_nxt = 5'h00;
    // a loss in the same cycle as a pop is still counted
    if (push && full && lost_word_count_r != `LOST_MAX)
      lost_word_count_nxt = lost_word_count_r + 5'h01;
    if (flush)
      lost_word_count_nxt = 5'h00;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      lost_word_count_r <= 5'h00;
    end
    else
    begin
      lost_word_count_r <= lost_word_count_nxt;
    end
  end

  always_comb
  begin
    count_nxt = count_r;
    // rollover keeps count pinned at full
    if (grow)
      count_nxt = count_r + 6'h01;
    else if (shrink)
      count_nxt = count_r - 6'h01;
    if (flush)
      count_nxt = 6'h00;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      count_r <= 6'h00;
    end
    else
    begin
      count_r <= count_nxt;
    end
  end

  always_comb
  begin
    cfg_nxt = cfg_r;
    if (watermark_wr)
      cfg_nxt.watermark = req.wdata[4:0];
    // flush is not stored: it acts at once and reads back as zero
    if (behaviour_wr)
    begin
      cfg_nxt.clear_on_data = req.wdata[`BIT_CLEAR_ON_DATA];
      cfg_nxt.flag_type = req.wdata[`BIT_FLAG_TYPE];
      cfg_nxt.overwrite = req.wdata[`BIT_OVERWRITE];
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cfg_r <= '0;
    end
    else
    begin
      cfg_r <= cfg_nxt;
    end
  end

  // flag evaluated on the post-update count
  always_comb
  begin
    cond_now = (count_nxt >= thresh) && (count_nxt != 6'h00);
    cond_nxt = cond_now;
    flag_nxt = flag_r;
    if (status_rd)
      flag_nxt = 1'b0;
    if (pop && cfg_r.clear_on_data)
      flag_nxt = 1'b0;
    // set wins over clear
    if (cfg_r.flag_type)
    begin
      if (cond_now && !cond_r)
        flag_nxt = 1'b1;
    end
    else if (cond_now && (push || !cond_r))
      flag_nxt = 1'b1;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      flag_r <= 1'b0;
      cond_r <= 1'b0;
    end
    else
    begin
      flag_r <= flag_nxt;
      cond_r <= cond_nxt;
    end
  end

  // an empty data port returns whatever its slot last held
  always_comb
  begin
    rdata_nxt = `RESET_BYTE;
    if (req.rd)
    begin
      unique case (req.addr)
        `ADDR_STATUS: rdata_nxt = {flag_r, 7'h00};
        `ADDR_WRITE_INDEX: rdata_nxt = {3'h0, write_index_r};
        `ADDR_READ_INDEX: rdata_nxt = {3'h0, read_index_r};
        `ADDR_LOST_COUNT: rdata_nxt = {3'h0, lost_word_count_r};
        `ADDR_UNREAD_COUNT: rdata_nxt = {2'h0, count_r};
        `ADDR_DATA_PORT: rdata_nxt = low_byte_r ?
          mem[read_index_r][7:0] : mem[read_index_r][15:8];
        `ADDR_WATERMARK: rdata_nxt = {3'h0, cfg_r.watermark};
        `ADDR_BEHAVIOUR: rdata_nxt = {4'h0, cfg_r.clear_on_data,
          cfg_r.flag_type, cfg_r.overwrite, 1'b0};
        default: rdata_nxt = `RESET_BYTE;
      endcase
    end
  end

  // registered so each byte stands one full cycle, then drops to zero
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rdata <= `RESET_BYTE;
    end
    else
    begin
      rdata <= rdata_nxt;
    end
  end

  assign almost_full = flag_r;
  // pin gates the registered flag with the unregistered enable and mode-select decode
  assign general_pin_0 = flag_r && almost_full_en
    && (pin0_function_select == `PIN0_INT_MODE);
endmodule
`default_nettype wire

// *** shared/sample_fifo_defines.svh ***
`ifndef SAMPLE_FIFO_DEFINES_SVH
`define SAMPLE_FIFO_DEFINES_SVH
`define ADDR_STATUS 8'h00
`define ADDR_INT_ENABLE 8'h01
`define ADDR_WRITE_INDEX 8'h04
`define ADDR_READ_INDEX 8'h05
`define ADDR_LOST_COUNT 8'h06
`define ADDR_UNREAD_COUNT 8'h07
`define ADDR_DATA_PORT 8'h08
`define ADDR_WATERMARK 8'h09
`define ADDR_BEHAVIOUR 8'h0a
`define ADDR_PIN_SETUP 8'h20
`define BIT_ALMOST_FULL 7
`define BIT_ALMOST_FULL_EN 7
`define BIT_FLUSH 4
`define BIT_CLEAR_ON_DATA 3
`define BIT_FLAG_TYPE 2
`define BIT_OVERWRITE 1
`define PIN0_SEL_LSB 0
`define PIN0_INT_MODE 2'h3
`define LOST_MAX 5'h1f
`define DEPTH_WORDS 6'h20
`define RESET_BYTE 8'h00
`endif

// *** shared/sample_fifo_pkg.sv ***
package sample_fifo_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
  typedef struct packed {
    logic [4:0] watermark;
    logic clear_on_data;
    logic flag_type;
    logic overwrite;
  } fifo_cfg_t;
endpackage

// *** verif/host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input wire logic ref_clk,
  input wire logic [7:0] rdata,
  output var sample_fifo_pkg::reg_req_t req
);
  initial req = '0;
  task automatic xfer(input logic w, input logic [7:0] a, d,
                      output logic [7:0] q);
    @(negedge ref_clk);
    req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge ref_clk);
    q = rdata;
    // released lines invert so stale values never look valid
    req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
endmodule
`default_nettype wire

// *** verif/temperature_sample_fifo_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
module fifo_checker (
  input wire logic ref_clk,
  input wire logic rst,
  input wire sample_fifo_pkg::reg_req_t req,
  input wire logic [7:0] rdata,
  input wire logic sample_valid,
  input wire logic [15:0] sample_word,
  input wire logic almost_full_en,
  input wire logic [1:0] pin0_function_select,
  input wire logic general_pin_0,
  input wire logic almost_full
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_stat;
    req.rd && req.addr == 8'h00 && !sample_valid;
  endsequence
  sequence s_rd(logic [7:0] a);
    req.rd && req.addr == a;
  endsequence
  property p_clr; s_stat |=> !almost_full; endproperty
  property p_pin; general_pin_0 == (almost_full && almost_full_en &&
    pin0_function_select == 2'h3); endproperty
  property p_rise; $rose(almost_full) |-> $past(sample_valid || req.wr);
  endproperty
  property p_fall; $fell(almost_full) |-> $past(req.rd || req.wr);
  endproperty
  property p_idle; !req.rd |=> rdata == 8'h00; endproperty
  property p_wi; s_rd(8'h04) |=> rdata[7:5] == 3'h0; endproperty
  property p_ri; s_rd(8'h05) |=> rdata[7:5] == 3'h0; endproperty
  property p_lost; s_rd(8'h06) |=> rdata[7:5] == 3'h0; endproperty
  property p_cnt; s_rd(8'h07) |=> rdata <= 8'h20; endproperty
  a_clr: assert property (p_clr) else $error("flag kept");
  a_pin: assert property (p_pin) else $error("pin wrong");
  a_rise: assert property (p_rise) else $error("flag rose");
  a_fall: assert property (p_fall) else $error("flag fell");
  a_idle: assert property (p_idle) else $error("rdata held");
  a_wi: assert property (p_wi) else $error("write index wide");
  a_ri: assert property (p_ri) else $error("read index wide");
  a_lost: assert property (p_lost) else $error("lost wide");
  a_cnt: assert property (p_cnt) else $error("count high");
endmodule
bind temperature_sample_fifo fifo_checker fifo_checker_i (.ref_clk, .rst,
  .req, .rdata, .sample_valid, .sample_word, .almost_full_en,
  .pin0_function_select, .general_pin_0, .almost_full);
`default_nettype wire

// *** verif/temperature_sample_fifo_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module temperature_sample_fifo_bench;
  logic ref_clk = 0;
  logic rst = 1;
  logic sample_valid = 0;
  logic [15:0] sample_word = '0;
  logic [7:0] rdata;
  logic [7:0] q;
  logic pin;
  logic af;
  logic en = 1'b1;
  logic [1:0] mode = 2'h3;
  sample_fifo_pkg::reg_req_t req;
  int n_fail = 0;
  int total_checks = 0;
  temperature_sample_fifo temperature_sample_fifo_i (.ref_clk, .rst, .req,
    .rdata, .sample_valid, .sample_word, .almost_full_en(en),
    .pin0_function_select(mode), .general_pin_0(pin), .almost_full(af));
  host_model host_model_i (.ref_clk, .rdata, .req);
  initial forever #50 ref_clk = ~ref_clk;
  function automatic logic [7:0] hi(int i);
    return 8'ha5 ^ i[7:0];
  endfunction
  function automatic logic [7:0] lo(int i);
    return i[7:0];
  endfunction
  function automatic logic [15:0] smp(int i);
    return {hi(i), lo(i)};
  endfunction
  task automatic chk(input logic [7:0] g, e);
    total_checks++;
    if (g !== e)
    begin
      $display("[ERR] %0t got %h exp %h", $time, g, e);
      n_fail++;
    end
  endtask
  task automatic rc(input logic [7:0] a, e);
    host_model_i.xfer(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask
  task automatic wr(input logic [7:0] a, d);
    host_model_i.xfer(1'b1, a, d, q);
  endtask
  task automatic push(int i);
    @(negedge ref_clk);
    sample_valid = 1'b1;
    sample_word = smp(i);
    @(negedge ref_clk);
    sample_valid = 1'b0;
  endtask
  task automatic t_reset;
    for (int a = 4; a < 11; a++)
      rc((a == 8) ? 8'h00 : a[7:0], 8'h00);
    rc(8'h40, 8'h00);
  endtask
  task automatic t_fill;
    wr(8'h09, 8'h02);
    for (int i = 0; i < 32; i++)
    begin
      push(i);
      if (i == 28 || i == 29 || i == 31) rc(8'h00, {i > 28, 7'h0});
    end
    rc(8'h04, 8'h00);
    push(32);
    chk({7'h0, af}, 8'h01);
    chk({7'h0, pin}, 8'h01);
    mode = 2'h2;
    @(negedge ref_clk);
    chk({7'h0, pin}, 8'h00);
    mode = 2'h3;
    en = 1'b0;
    @(negedge ref_clk);
    chk({7'h0, pin}, 8'h00);
    en = 1'b1;
    rc(8'h06, 8'h01);
    rc(8'h07, 8'h20);
    rc(8'h08, hi(0));
    rc(8'h08, lo(0));
    rc(8'h05, 8'h01);
    rc(8'h06, 8'h00);
    rc(8'h07, 8'h1f);
  endtask
  task automatic t_reread;
    wr(8'h05, 8'h00);
    rc(8'h08, hi(0));
    rc(8'h08, lo(0));
  endtask
  task automatic t_roll;
    wr(8'h0a, 8'h10);
    wr(8'h0a, 8'h0a);
    for (int i = 40; i < 73; i++) push(i);
    rc(8'h05, 8'h01);
    rc(8'h06, 8'h01);
    rc(8'h07, 8'h20);
    rc(8'h08, hi(41));
    rc(8'h08, lo(41));
    rc(8'h00, 8'h00);
  endtask
  task automatic t_type;
    wr(8'h0a, 8'h14);
    wr(8'h09, 8'h1e);
    push(50);
    rc(8'h00, 8'h00);
    push(51);
    rc(8'h00, 8'h80);
    push(52);
    rc(8'h00, 8'h00);
  endtask
  task automatic t_flush;
    wr(8'h0a, 8'h10);
    for (int a = 4; a < 8; a++) rc(a[7:0], 8'h00);
    rc(8'h0a, 8'h00);
  endtask
  task automatic conclude;
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    t_reset();
    t_fill();
    t_reread();
    t_roll();
    t_type();
    t_flush();
    conclude();
  end
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    conclude();
  end
endmodule
`default_nettype wire
